// ==== rtl/fbd_pkg.sv ====
`default_nettype none
package fbd_pkg;
  // ---------------------------------------------------------------
  // Register map (APB byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] INSTR_ADDR = 8'h04;
  localparam logic [7:0] FILEIN_ADDR = 8'h08;
  localparam logic [7:0] ACC_ADDR = 8'h0c;
  localparam logic [7:0] STATUS_ADDR = 8'h10;
  localparam logic [7:0] RESULT_ADDR = 8'h14;
  localparam logic [7:0] PC_ADDR = 8'h18;
  localparam logic [7:0] CYCLES_ADDR = 8'h1c;
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CARRY_POS = 0;
  localparam int DIGIT_POS = 1;
  localparam int ZERO_POS = 2;
  localparam int PD_POS = 3;
  localparam int TO_POS = 4;
  localparam int PRESC_POS = 1;
  localparam int IOREG_POS = 2;
  localparam logic [4:0] STATUS_RST = 5'h18;
  localparam logic [7:0] TIMER_ADDR = 8'h01;
  localparam logic [1:0] QUARTERS = 2'h3;
  localparam int STACK_DEPTH = 8;
  localparam logic [31:0] ERR_DATA = 32'hdeadbeef;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_NOP = 2'b10
  } fbd_state_t;
endpackage
`default_nettype wire

// ==== rtl/fbd_decoder.sv ====
`default_nettype none
module fbd_decoder
  import fbd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] pinLevels,
  output logic prescalerClear,
  output logic fileWrite,
  output logic [6:0] fileAddr,
  output logic [7:0] fileData
);
  // ---------------------------------------------------------------
  // Pin synchroniser and bus signals
  // ---------------------------------------------------------------
  logic [7:0] pinMeta_reg;
  logic [7:0] pinSync_reg;
  logic busWrite;
  logic busRead;
  assign busWrite = psel && penable && pwrite && !pready;
  assign busRead = psel && penable && !pwrite && !pready;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinMeta_reg <= 8'h00;
      pinSync_reg <= 8'h00;
    end else begin
      pinMeta_reg <= pinLevels;
      pinSync_reg <= pinMeta_reg;
    end
  end
  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  logic [2:0] ctrl_reg;
  logic [13:0] instr_reg;
  logic [7:0] fileIn_reg;
  logic [7:0] acc_reg;
  logic [4:0] status_reg;
  logic [7:0] result_reg;
  logic [12:0] pc_reg;
  logic [3:0] cycles_reg;
  fbd_state_t state_reg;
  logic [1:0] quarter_reg;
  logic [2:0] sp_reg;
  logic [12:0] stack_reg [STACK_DEPTH];
  logic start;
  assign start = busWrite && paddr == CTRL_ADDR && pwdata[0]
                 && state_reg == ST_IDLE;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= 3'h0;
      instr_reg <= 14'h0000;
      fileIn_reg <= 8'h00;
    end else if (busWrite) begin
      case (paddr)
        CTRL_ADDR: ctrl_reg <= {pwdata[2:1], 1'b0};
        INSTR_ADDR: instr_reg <= pwdata[13:0];
        FILEIN_ADDR: fileIn_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // Execute logic
  // ---------------------------------------------------------------
  logic [7:0] op;
  logic [7:0] lit;
  logic [2:0] bitSel;
  logic dest;
  logic [7:0] res;
  logic [4:0] st;
  logic toAcc;
  logic toFile;
  logic skip;
  logic jump;
  logic doCall;
  logic doRet;
  logic [12:0] target;
  logic timerHit;
  function automatic logic [9:0] add8(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    add8 = {full[8], lo[4], full[7:0]};
  endfunction
  always_comb begin
    logic [9:0] sum;
    sum = 10'h000;
    // Port self-modify uses pin levels, not latch contents
    op = ctrl_reg[IOREG_POS] ? pinSync_reg : fileIn_reg;
    lit = instr_reg[7:0];
    bitSel = instr_reg[9:7];
    dest = instr_reg[7];
    res = acc_reg;
    st = status_reg;
    toAcc = 1'b0;
    toFile = 1'b0;
    skip = 1'b0;
    jump = 1'b0;
    doCall = 1'b0;
    doRet = 1'b0;
    target = pc_reg + 13'h0001;
    case (instr_reg[13:12])
      2'b00: begin
        toAcc = !dest;
        toFile = dest;
        case (instr_reg[11:8])
          4'h0: begin
            toAcc = 1'b0;
            toFile = dest;
            res = acc_reg;
            if (!dest) begin
              case (instr_reg[6:0])
                7'h08, 7'h09: begin
                  doRet = 1'b1;
                  jump = 1'b1;
                end
                7'h63: begin
                  st[TO_POS] = 1'b1;
                  st[PD_POS] = 1'b0;
                end
                7'h64: begin
                  st[TO_POS] = 1'b1;
                  st[PD_POS] = 1'b1;
                end
                default: ;
              endcase
            end
          end
          4'h1: begin
            res = 8'h00;
            st[ZERO_POS] = 1'b1;
          end
          4'h2, 4'h7: begin
            if (instr_reg[11:8] == 4'h2) sum = add8(op, ~acc_reg, 1'b1);
            else sum = add8(op, acc_reg, 1'b0);
            res = sum[7:0];
            st[CARRY_POS] = sum[9];
            st[DIGIT_POS] = sum[8];
            st[ZERO_POS] = sum[7:0] == 8'h00;
          end
          4'h3, 4'h5, 4'h8, 4'h9, 4'ha, 4'h4, 4'h6: begin
            case (instr_reg[11:8])
              4'h3: res = op - 8'h01;
              4'h5: res = op & acc_reg;
              4'h8: res = op;
              4'h9: res = ~op;
              4'ha: res = op + 8'h01;
              4'h4: res = op | acc_reg;
              default: res = op ^ acc_reg;
            endcase
            st[ZERO_POS] = res == 8'h00;
          end
          4'hb, 4'hf: begin
            res = instr_reg[10] ? op + 8'h01 : op - 8'h01;
            skip = res == 8'h00;
          end
          4'hd: begin
            res = {op[6:0], status_reg[CARRY_POS]};
            st[CARRY_POS] = op[7];
          end
          4'hc: begin
            res = {status_reg[CARRY_POS], op[7:1]};
            st[CARRY_POS] = op[0];
          end
          default: res = {op[3:0], op[7:4]};
        endcase
      end
      2'b01: begin
        res = op;
        case (instr_reg[11:10])
          2'b00: begin
            res[bitSel] = 1'b0;
            toFile = 1'b1;
          end
          2'b01: begin
            res[bitSel] = 1'b1;
            toFile = 1'b1;
          end
          2'b10: skip = !op[bitSel];
          default: skip = op[bitSel];
        endcase
      end
      2'b10: begin
        jump = 1'b1;
        doCall = !instr_reg[11];
        target = {2'b00, instr_reg[10:0]};
      end
      default: begin
        toAcc = 1'b1;
        case (instr_reg[11:8])
          4'h0, 4'h1, 4'h2, 4'h3: res = lit;
          4'h4, 4'h5, 4'h6, 4'h7: begin
            res = lit;
            doRet = 1'b1;
            jump = 1'b1;
          end
          4'h8: begin
            res = lit | acc_reg;
            st[ZERO_POS] = res == 8'h00;
          end
          4'h9: begin
            res = lit & acc_reg;
            st[ZERO_POS] = res == 8'h00;
          end
          4'ha: begin
            res = lit ^ acc_reg;
            st[ZERO_POS] = res == 8'h00;
          end
          4'hc, 4'hd, 4'he, 4'hf: begin
            if (instr_reg[9]) sum = add8(lit, acc_reg, 1'b0);
            else sum = add8(lit, ~acc_reg, 1'b1);
            res = sum[7:0];
            st[CARRY_POS] = sum[9];
            st[DIGIT_POS] = sum[8];
            st[ZERO_POS] = sum[7:0] == 8'h00;
          end
          default: toAcc = 1'b0;
        endcase
      end
    endcase
    if (doRet) target = stack_reg[sp_reg - 3'h1];
    if (skip) target = pc_reg + 13'h0002;
  end
  assign timerHit = toFile && {1'b0, instr_reg[6:0]} == TIMER_ADDR;
  // ---------------------------------------------------------------
  // Instruction sequencer
  // ---------------------------------------------------------------
  logic lastQ;
  assign lastQ = quarter_reg == QUARTERS;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      quarter_reg <= 2'h0;
      cycles_reg <= 4'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_EXEC;
            quarter_reg <= 2'h0;
            cycles_reg <= 4'h0;
          end
        end
        ST_EXEC: begin
          quarter_reg <= quarter_reg + 2'h1;
          cycles_reg <= cycles_reg + 4'h1;
          if (lastQ) state_reg <= (skip || jump) ? ST_NOP : ST_IDLE;
        end
        ST_NOP: begin
          quarter_reg <= quarter_reg + 2'h1;
          cycles_reg <= cycles_reg + 4'h1;
          if (lastQ) state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  logic commit;
  assign commit = state_reg == ST_EXEC && lastQ;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_reg <= 8'h00;
      status_reg <= STATUS_RST;
      result_reg <= 8'h00;
      pc_reg <= 13'h0000;
      sp_reg <= 3'h0;
      fileWrite <= 1'b0;
      fileAddr <= 7'h00;
      fileData <= 8'h00;
      prescalerClear <= 1'b0;
    end else begin
      fileWrite <= commit && toFile;
      prescalerClear <= commit && timerHit
                        && ctrl_reg[PRESC_POS];
      if (commit) begin
        status_reg <= st;
        result_reg <= res;
        pc_reg <= target;
        fileAddr <= instr_reg[6:0];
        fileData <= res;
        if (toAcc) acc_reg <= res;
        if (doCall) begin
          sp_reg <= sp_reg + 3'h1;
        end else if (doRet) begin
          sp_reg <= sp_reg - 3'h1;
        end
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (commit && doCall) begin
      stack_reg[sp_reg] <= pc_reg + 13'h0001;
    end
  end
  // ---------------------------------------------------------------
  // APB read path
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      if (busRead) begin
        case (paddr)
          CTRL_ADDR: prdata <= {29'h0, ctrl_reg[2:1], state_reg != ST_IDLE};
          INSTR_ADDR: prdata <= {18'h0, instr_reg};
          FILEIN_ADDR: prdata <= {24'h0, fileIn_reg};
          ACC_ADDR: prdata <= {24'h0, acc_reg};
          STATUS_ADDR: prdata <= {27'h0, status_reg};
          RESULT_ADDR: prdata <= {24'h0, result_reg};
          PC_ADDR: prdata <= {19'h0, pc_reg};
          CYCLES_ADDR: prdata <= {28'h0, cycles_reg};
          default: begin
            prdata <= ERR_DATA;
            pslverr <= 1'b1;
          end
        endcase
      end else if (busWrite) begin
        pslverr <= !(paddr == CTRL_ADDR || paddr == INSTR_ADDR
                     || paddr == FILEIN_ADDR);
      end
    end
  end
endmodule // fbd_decoder
`default_nettype wire

// ==== sim/fbd_decoder_sva.sv ====
`default_nettype none
module fbd_decoder_sva
  import fbd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic prescalerClear,
  input wire logic fileWrite
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Bus and execution checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence accFirst;
    psel && penable && !pready;
  endsequence
  sequence startWr;
    pready && pwrite && paddr == CTRL_ADDR && pwdata[0];
  endsequence
  AST_PREADY_NEXT: assert property (accFirst |=> pready)
    else $error("pready late");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready too long");
  AST_PREADY_ACC: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  AST_ERR_ADDR: assert property (pready && paddr[1:0] == 2'h0 |->
    pslverr == (paddr > CYCLES_ADDR || (pwrite && paddr > FILEIN_ADDR)))
    else $error("pslverr wrong");
  AST_ERR_DATA: assert property (pready && pslverr && !pwrite |->
    prdata == ERR_DATA)
    else $error("error data wrong");
  AST_ACC_WIDTH: assert property (pready && !pwrite && !pslverr &&
    paddr == ACC_ADDR |-> prdata[31:8] == 24'h0)
    else $error("acc upper bits set");
  AST_FW_PULSE: assert property (fileWrite |=> !fileWrite)
    else $error("file write too long");
  AST_PSC_PULSE: assert property (
    prescalerClear |=> !prescalerClear)
    else $error("prescaler clear too long");
  AST_EXEC_MIN: assert property (startWr |=> !fileWrite [*3])
    else $error("write before four clocks");
endmodule // fbd_decoder_sva
bind fbd_decoder fbd_decoder_sva uSva (.sys_clk(sys_clk), .rst(rst),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .prescalerClear(prescalerClear), .fileWrite(fileWrite));
`default_nettype wire

// ==== sim/fbd_file_model.sv ====
`default_nettype none
module fbd_file_model #(
  parameter logic [7:0] PINS = 8'ha5
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic fileWrite,
  input wire logic [6:0] fileAddr,
  input wire logic [7:0] fileData,
  input wire logic prescalerClear,
  output logic [7:0] pinLevels,
  output logic [14:0] lastWrite,
  output logic [7:0] pscCount
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins differ from any operand the bench loads
  assign pinLevels = PINS;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lastWrite <= 15'h0000;
      pscCount <= 8'h00;
    end else begin
      if (fileWrite) begin
        lastWrite <= {fileAddr, fileData};
      end
      if (prescalerClear) begin
        pscCount <= pscCount + 8'h01;
      end
    end
  end
endmodule // fbd_file_model
`default_nettype wire

// ==== sim/fbd_decoder_tb.sv ====
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("BAD %0t got %h want %h", $time, g, e); end end
module fbd_decoder_tb
  import fbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic prescalerClear, fileWrite;
  logic [7:0] paddr, pinLevels, fileData, pscCount;
  logic [6:0] fileAddr;
  logic [14:0] lastWrite;
  logic [31:0] pwdata, prdata, q, pcVal;
  int errors, n_checks;
  fbd_decoder DUT (.sys_clk(sys_clk), .rst(rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pinLevels(pinLevels), .prescalerClear(prescalerClear),
    .fileWrite(fileWrite), .fileAddr(fileAddr), .fileData(fileData));
  fbd_file_model uModel (.sys_clk(sys_clk), .rst(rst),
    .fileWrite(fileWrite), .fileAddr(fileAddr), .fileData(fileData),
    .prescalerClear(prescalerClear), .pinLevels(pinLevels),
    .lastWrite(lastWrite), .pscCount(pscCount));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    xfer(a, 1'b0, 32'h0);
    `CHK({e, q}, {1'b0, x});
  endtask
  task automatic step(input logic [13:0] ins, input logic [7:0] fin,
    input logic [2:0] ctl, input logic [7:0] acc, input logic [4:0] st,
    input logic [31:0] cyc);
    xfer(INSTR_ADDR, 1'b1, {18'h0, ins});
    xfer(FILEIN_ADDR, 1'b1, {24'h0, fin});
    xfer(CTRL_ADDR, 1'b1, {29'h0, ctl | 3'h1});
    q = 32'h1;
    for (int i = 0; i < 30 && q[0] !== 1'b0; i++) begin
      xfer(CTRL_ADDR, 1'b0, 32'h0);
    end
    rd(CYCLES_ADDR, cyc);
    rd(ACC_ADDR, {24'h0, acc});
    rd(STATUS_ADDR, {27'h0, st});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge sys_clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    errors = 0;
    n_checks = 0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(STATUS_ADDR, {27'h0, STATUS_RST});
    step(14'h305a, 8'h00, 3'h0, 8'h5a, 5'h18, 4);
    step(14'h0620, 8'h5a, 3'h0, 8'h00, 5'h1c, 4);
    step(14'h04a0, 8'h81, 3'h0, 8'h00, 5'h18, 4);
    `CHK(lastWrite, {7'h20, 8'h81});
    step(14'h0d20, 8'h81, 3'h0, 8'h02, 5'h19, 4);
    step(14'h0c20, 8'h02, 3'h0, 8'h81, 5'h18, 4);
    step(14'h0b20, 8'h01, 3'h0, 8'h00, 5'h18, 8);
    step(14'h0f20, 8'hff, 3'h0, 8'h00, 5'h18, 8);
    step(14'h0f20, 8'hfe, 3'h0, 8'hff, 5'h18, 4);
    step(14'h19a0, 8'h00, 3'h0, 8'hff, 5'h18, 8);
    step(14'h19a0, 8'h08, 3'h0, 8'hff, 5'h18, 4);
    step(14'h1da0, 8'h08, 3'h0, 8'hff, 5'h18, 8);
    step(14'h1da0, 8'hf7, 3'h0, 8'hff, 5'h18, 4);
    step(14'h3010, 8'h00, 3'h0, 8'h10, 5'h18, 4);
    step(14'h3c25, 8'h00, 3'h0, 8'h15, 5'h1b, 4);
    step(14'h3a15, 8'h00, 3'h0, 8'h00, 5'h1f, 4);
    step(14'h3840, 8'h00, 3'h0, 8'h40, 5'h1b, 4);
    xfer(PC_ADDR, 1'b0, 32'h0);
    pcVal = q;
    step(14'h2123, 8'h00, 3'h0, 8'h40, 5'h1b, 8);
    rd(PC_ADDR, 32'h123);
    step(14'h3433, 8'h00, 3'h0, 8'h33, 5'h1b, 8);
    rd(PC_ADDR, pcVal + 32'h1);
    step(14'h0063, 8'h00, 3'h0, 8'h33, 5'h13, 4);
    step(14'h0064, 8'h00, 3'h0, 8'h33, 5'h1b, 4);
    step(14'h08a0, 8'h3c, 3'h0, 8'h33, 5'h1b, 4);
    `CHK(lastWrite, {7'h20, 8'h3c});
    step(14'h08a0, 8'h3c, 3'h4, 8'h33, 5'h1b, 4);
    `CHK(lastWrite, {7'h20, 8'ha5});
    step(14'h0081, 8'h00, 3'h2, 8'h33, 5'h1b, 4);
    `CHK(pscCount, 8'h01);
    step(14'h0801, 8'h00, 3'h2, 8'h00, 5'h1f, 4);
    step(14'h0081, 8'h00, 3'h0, 8'h00, 5'h1f, 4);
    `CHK(pscCount, 8'h01);
    step(14'h300f, 8'h00, 3'h0, 8'h0f, 5'h1f, 4);
    step(14'h0720, 8'h01, 3'h0, 8'h10, 5'h1a, 4);
    step(14'h0220, 8'h05, 3'h0, 8'hf5, 5'h1a, 4);
    step(14'h0520, 8'h0f, 3'h0, 8'h05, 5'h1a, 4);
    step(14'h0920, 8'hff, 3'h0, 8'h00, 5'h1e, 4);
    step(14'h0320, 8'h00, 3'h0, 8'hff, 5'h1a, 4);
    step(14'h0100, 8'h00, 3'h0, 8'h00, 5'h1e, 4);
    step(14'h0a20, 8'hff, 3'h0, 8'h00, 5'h1e, 4);
    step(14'h0e20, 8'h3c, 3'h0, 8'hc3, 5'h1e, 4);
    step(14'h01a0, 8'h55, 3'h0, 8'hc3, 5'h1e, 4);
    `CHK(lastWrite, {7'h20, 8'h00});
    step(14'h39f0, 8'h00, 3'h0, 8'hc0, 5'h1a, 4);
    step(14'h3e40, 8'h00, 3'h0, 8'h00, 5'h1d, 4);
    step(14'h15a0, 8'h00, 3'h0, 8'h00, 5'h1d, 4);
    `CHK(lastWrite, {7'h20, 8'h08});
    step(14'h11a0, 8'hff, 3'h0, 8'h00, 5'h1d, 4);
    `CHK(lastWrite, {7'h20, 8'hf7});
    step(14'h2855, 8'h00, 3'h0, 8'h00, 5'h1d, 8);
    rd(PC_ADDR, 32'h55);
    step(14'h2200, 8'h00, 3'h0, 8'h00, 5'h1d, 8);
    step(14'h2300, 8'h00, 3'h0, 8'h00, 5'h1d, 8);
    step(14'h0008, 8'h00, 3'h0, 8'h00, 5'h1d, 8);
    rd(PC_ADDR, 32'h201);
    step(14'h0009, 8'h00, 3'h0, 8'h00, 5'h1d, 8);
    rd(PC_ADDR, 32'h56);
    xfer(8'h40, 1'b0, 32'h0);
    `CHK({e, q}, {1'b1, ERR_DATA});
    xfer(ACC_ADDR, 1'b1, 32'h0);
    `CHK(e, 1'b1);
    tally_and_finish();
  end
endmodule // fbd_decoder_tb
`default_nettype wire
